// ### logic/lhc_host.sv
// Summary of operation
// - host builds table, presets result code ffh
// - host loads table address into address fifo
// - check fifo write flag before each write
// - address is three bytes, complete after third
// - empty fifo: controller uses default address
// - host requests by pin or control bit
// - completion raises interrupt pin and status flag
// - host clears interrupt by pin or bit
// - after clearing, host reads the completion code
// - one clear drops command and receive causes
// - code ffh or feh means receive interrupt
// - default fetch address is zero after reset
// - accepted command writes code 00h
// - refused in monitor state writes code 8ah
//
// The register addresses and the APB register port were chosen for this implementation.
module lhc_host #(
  parameter int MEM_BYTES = 64
) (
  // link to the controller
  lhc_if.host lnk,
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt to software
  output logic irq
);
  localparam int AW = $clog2(MEM_BYTES);
  typedef enum logic [3:0] {
    H_IDLE, H_BUILD, H_POLL, H_CHECK, H_PUSH, H_GAP, H_REQ, H_WAIT,
    H_CLEAR, H_SETTLE, H_READ
  } lhc_hst_t;

  lhc_hst_t state_ff;
  logic [7:0] mem [MEM_BYTES];
  logic pready_ff, pslverr_ff, pin_mode_ff, irq_ff;
  logic [31:0] prdata_ff;
  logic [7:0] cmd_ff, result_ff, mrdata_ff, wdata_ff;
  logic [AW-1:0] table_ff;
  logic [23:0] param_ff, rptr24, tbl24;
  logic [1:0] stat_ff, en_ff, nxt_stat, set_ev;
  logic [2:0] idx_ff;
  logic [1:0] bcnt_ff;
  logic mack_ff, crq_ff, clr_ff, cs_ff, wr_ff, addr_ff;
  logic done, wr_fire, start, hit, seen;
  logic [7:0] build_byte, code;
  logic [31:0] rd_data;

  // ****************************************
  // apb slave, one wait state
  // ****************************************
  assign done = psel & penable & pready_ff;
  assign wr_fire = done & pwrite;
  assign start = wr_fire & (paddr == lhc_pkg::A_CTRL)
    & pwdata[lhc_pkg::HC_START] & (state_ff == H_IDLE);

  // read mux and decode
  always_comb begin
    rd_data = '0;
    hit = 1'b1;
    unique case (paddr)
      lhc_pkg::A_CTRL: rd_data[lhc_pkg::HC_PIN_MODE] = pin_mode_ff;
      lhc_pkg::A_CMD: rd_data[7:0] = cmd_ff;
      lhc_pkg::A_TABLE: rd_data[AW-1:0] = table_ff;
      lhc_pkg::A_PARAM: rd_data[23:0] = param_ff;
      lhc_pkg::A_RESULT: begin
        rd_data[7:0] = result_ff;
        rd_data[lhc_pkg::RES_BUSY] = (state_ff != H_IDLE);
      end
      lhc_pkg::A_INT_STAT: rd_data[1:0] = stat_ff;
      lhc_pkg::A_INT_EN: rd_data[1:0] = en_ff;
      lhc_pkg::A_INT_CLR: rd_data = '0;
      default: hit = 1'b0;
    endcase
  end

  // handshake and read data
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else begin
      pready_ff <= psel & penable & ~pready_ff;
      pslverr_ff <= psel & penable & ~pready_ff & ~hit;
      prdata_ff <= (psel & penable & ~pready_ff & ~pwrite) ? rd_data : '0;
    end
  end

  // writable registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_mode_ff <= 1'b0;
      cmd_ff <= '0;
      table_ff <= '0;
      param_ff <= '0;
      en_ff <= '0;
    end else if (wr_fire) begin
      unique case (paddr)
        lhc_pkg::A_CTRL: pin_mode_ff <= pwdata[lhc_pkg::HC_PIN_MODE];
        lhc_pkg::A_CMD: cmd_ff <= pwdata[7:0];
        lhc_pkg::A_TABLE: table_ff <= pwdata[AW-1:0];
        lhc_pkg::A_PARAM: param_ff <= pwdata[23:0];
        lhc_pkg::A_INT_EN: en_ff <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // shared memory
  // ****************************************
  assign tbl24 = 24'(table_ff);
  assign rptr24 = 24'(table_ff + AW'(lhc_pkg::TBL_RESULT));
  assign code = mem[rptr24[AW-1:0]];

  // table bytes: opcode, result pointer, parameter, preset code
  always_comb begin
    build_byte = lhc_pkg::CODE_IDLE;
    unique case (idx_ff)
      3'd0: build_byte = cmd_ff;
      3'd1: build_byte = rptr24[7:0];
      3'd2: build_byte = rptr24[15:8];
      3'd3: build_byte = rptr24[23:16];
      3'd4: build_byte = param_ff[7:0];
      3'd5: build_byte = param_ff[15:8];
      3'd6: build_byte = param_ff[23:16];
      3'd7: build_byte = lhc_pkg::CODE_IDLE;
    endcase
  end

  // table build and controller writes
  always_ff @(posedge clk) begin
    if (state_ff == H_BUILD) begin
      mem[table_ff + AW'(idx_ff)] <= build_byte;
    end else if (lnk.mem_req & lnk.mem_we & ~mack_ff) begin
      mem[lnk.mem_addr[AW-1:0]] <= lnk.mem_wdata;
    end
  end

  // one acknowledge per request
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mack_ff <= 1'b0;
      mrdata_ff <= '0;
    end else begin
      mack_ff <= lnk.mem_req & ~mack_ff;
      mrdata_ff <= mem[lnk.mem_addr[AW-1:0]];
    end
  end

  // ****************************************
  // command issue sequence
  // ****************************************
  assign seen = pin_mode_ff ? lnk.interrupt_pin
    : lnk.reg_rdata[lhc_pkg::ST_IRQ];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= H_IDLE;
      idx_ff <= '0;
      bcnt_ff <= '0;
      crq_ff <= 1'b0;
      clr_ff <= 1'b0;
      cs_ff <= 1'b0;
      wr_ff <= 1'b0;
      addr_ff <= lhc_pkg::REG_CTRL;
      wdata_ff <= '0;
      result_ff <= lhc_pkg::CODE_IDLE;
    end else begin
      unique case (state_ff)
        H_IDLE: begin
          if (start) begin
            idx_ff <= '0;
            state_ff <= H_BUILD;
          end
        end
        H_BUILD: begin
          idx_ff <= idx_ff + 3'd1;
          if (idx_ff == 3'(lhc_pkg::TBL_RESULT)) begin
            bcnt_ff <= '0;
            state_ff <= H_POLL;
          end
        end
        H_POLL: begin
          cs_ff <= 1'b1;
          wr_ff <= 1'b0;
          addr_ff <= lhc_pkg::REG_CTRL;
          state_ff <= H_CHECK;
        end
        H_CHECK: begin
          // write only while the fifo accepts bytes
          cs_ff <= 1'b0;
          state_ff <= lnk.reg_rdata[lhc_pkg::ST_WR_OK]
            ? H_PUSH : H_POLL;
        end
        H_PUSH: begin
          cs_ff <= 1'b1;
          wr_ff <= 1'b1;
          addr_ff <= lhc_pkg::REG_FIFO;
          wdata_ff <= tbl24[8*bcnt_ff +: 8];
          bcnt_ff <= bcnt_ff + 2'd1;
          state_ff <= H_GAP;
        end
        H_GAP: begin
          cs_ff <= 1'b0;
          wr_ff <= 1'b0;
          state_ff <= (bcnt_ff == 2'(lhc_pkg::ADDR_BYTES))
            ? H_REQ : H_POLL;
        end
        H_REQ: begin
          if (pin_mode_ff) begin
            crq_ff <= 1'b1;
          end else begin
            cs_ff <= 1'b1;
            wr_ff <= 1'b1;
            addr_ff <= lhc_pkg::REG_CTRL;
            wdata_ff <= 8'(1 << lhc_pkg::CT_REQ);
          end
          state_ff <= H_WAIT;
        end
        H_WAIT: begin
          crq_ff <= 1'b0;
          cs_ff <= ~pin_mode_ff;
          wr_ff <= 1'b0;
          addr_ff <= lhc_pkg::REG_CTRL;
          // a cause already gone is never seen here
          if (seen) state_ff <= H_CLEAR;
        end
        H_CLEAR: begin
          if (pin_mode_ff) begin
            clr_ff <= 1'b1;
          end else begin
            cs_ff <= 1'b1;
            wr_ff <= 1'b1;
            wdata_ff <= 8'(1 << lhc_pkg::CT_CLR);
          end
          state_ff <= H_SETTLE;
        end
        H_SETTLE: begin
          clr_ff <= 1'b0;
          cs_ff <= 1'b0;
          wr_ff <= 1'b0;
          state_ff <= H_READ;
        end
        H_READ: begin
          // untouched code means only a receive was pending
          if (code == lhc_pkg::CODE_IDLE
              || code == lhc_pkg::CODE_RX) begin
            state_ff <= H_WAIT;
          end else begin
            result_ff <= code;
            state_ff <= H_IDLE;
          end
        end
        default: state_ff <= H_IDLE;
      endcase
    end
  end

  // ****************************************
  // interrupt status, set wins over clear
  // ****************************************
  always_comb begin
    set_ev = '0;
    set_ev[lhc_pkg::INT_RX] = (state_ff == H_READ)
      & (code == lhc_pkg::CODE_IDLE || code == lhc_pkg::CODE_RX);
    set_ev[lhc_pkg::INT_DONE] = (state_ff == H_READ)
      & ~(code == lhc_pkg::CODE_IDLE || code == lhc_pkg::CODE_RX);
    nxt_stat = stat_ff;
    if (wr_fire && paddr == lhc_pkg::A_INT_CLR) begin
      nxt_stat = stat_ff & ~pwdata[1:0];
    end
    nxt_stat = nxt_stat | set_ev;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stat_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      stat_ff <= nxt_stat;
      irq_ff <= |(nxt_stat & en_ff);
    end
  end

  // outputs
  assign lnk.command_request_pin = crq_ff;
  assign lnk.interrupt_clear_pin = clr_ff;
  assign lnk.reg_cs = cs_ff;
  assign lnk.reg_wr = wr_ff;
  assign lnk.reg_addr = addr_ff;
  assign lnk.reg_wdata = wdata_ff;
  assign lnk.mem_ack = mack_ff;
  assign lnk.mem_rdata = mrdata_ff;
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq = irq_ff;
endmodule : lhc_host

// ### pkg/lhc_pkg.sv
// ****************************************
// shared constants of the command link
// ****************************************
package lhc_pkg;
  localparam int ADDR_W = 24;
  // completion codes
  localparam logic [7:0] CODE_IDLE = 8'hff;
  localparam logic [7:0] CODE_RX = 8'hfe;
  localparam logic [7:0] CODE_OK = 8'h00;
  localparam logic [7:0] CODE_MONITOR = 8'h8a;
  // opcode of the default fetch address command
  localparam logic [7:0] OP_SET_DEFAULT = 8'h0f;
  // controller status and control bit positions
  localparam int ST_WR_OK = 1;
  localparam int ST_IRQ = 4;
  localparam int CT_REQ = 0;
  localparam int CT_CLR = 3;
  // controller register select and default fetch address after reset
  localparam logic REG_CTRL = 1'b0;
  localparam logic REG_FIFO = 1'b1;
  localparam logic [23:0] DEFAULT_RESET = 24'h000000;
  // command table layout, byte offsets
  localparam int TBL_OP = 0;
  localparam int TBL_RPTR_LAST = 3;
  localparam int TBL_PARAM_LAST = 6;
  localparam int TBL_RESULT = 7;
  localparam int ADDR_BYTES = 3;
  // host register map over apb
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CMD = 8'h04;
  localparam logic [7:0] A_TABLE = 8'h08;
  localparam logic [7:0] A_PARAM = 8'h0c;
  localparam logic [7:0] A_RESULT = 8'h10;
  localparam logic [7:0] A_INT_STAT = 8'h14;
  localparam logic [7:0] A_INT_EN = 8'h18;
  localparam logic [7:0] A_INT_CLR = 8'h1c;
  // host control and interrupt bits
  localparam int HC_START = 0;
  localparam int HC_PIN_MODE = 1;
  localparam int INT_DONE = 0;
  localparam int INT_RX = 1;
  localparam int RES_BUSY = 8;
endpackage : lhc_pkg

// ### pkg/lhc_if.sv
// ****************************************
// pins between host and controller
// ****************************************
interface lhc_if;
  // request and interrupt pins
  logic command_request_pin;
  logic interrupt_clear_pin;
  logic interrupt_pin;
  // controller register port
  logic reg_cs;
  logic reg_wr;
  logic reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  // shared memory port, controller is master
  logic mem_req;
  logic mem_we;
  logic [23:0] mem_addr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  logic mem_ack;

  modport ctrl (
    input command_request_pin, interrupt_clear_pin,
    input reg_cs, reg_wr, reg_addr, reg_wdata,
    input mem_rdata, mem_ack,
    output interrupt_pin, reg_rdata,
    output mem_req, mem_we, mem_addr, mem_wdata
  );
  modport host (
    output command_request_pin, interrupt_clear_pin,
    output reg_cs, reg_wr, reg_addr, reg_wdata,
    output mem_rdata, mem_ack,
    input interrupt_pin, reg_rdata,
    input mem_req, mem_we, mem_addr, mem_wdata
  );
endinterface : lhc_if

// ### logic/lhc_ctrl.sv
// ****************************************
// controller end: fifo, fetch, completion
// ****************************************
module lhc_ctrl #(
  parameter int FIFO_DEPTH = 4
) (
  // link to the host
  lhc_if.ctrl lnk,
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // command execution side
  output logic exe_valid,
  output logic [7:0] exe_code,
  output logic [23:0] exe_table,
  input wire logic exe_done,
  input wire logic exe_refused,
  input wire logic rx_event
);
  localparam int PW = $clog2(FIFO_DEPTH);
  typedef enum logic [1:0] {C_IDLE, C_FETCH, C_EXEC, C_WRITE} lhc_cst_t;

  lhc_cst_t state_ff;
  logic [23:0] fifo_mem [FIFO_DEPTH];
  logic [PW-1:0] wp_ff, rp_ff;
  logic [PW:0] cnt_ff;
  logic [1:0] bcnt_ff;
  logic [23:0] asm_ff, dflt_ff, base_ff, rptr_ff, prm_ff, maddr_ff;
  logic [7:0] op_ff, wdat_ff, rdata_ff;
  logic [2:0] idx_ff;
  logic mreq_ff, mwe_ff, req_pend_ff, cmd_pend_ff, rx_pend_ff, irq_ff;
  logic exe_valid_ff;
  logic reg_wr, ctrl_wr, push_byte, push_ok, pop, full, empty;
  logic req_in, clr_in, start, done_set, nxt_cmd_pend, nxt_rx_pend;
  logic [7:0] stat;

  // ****************************************
  // register port decode
  // ****************************************
  assign reg_wr = lnk.reg_cs & lnk.reg_wr;
  assign ctrl_wr = reg_wr & (lnk.reg_addr == lhc_pkg::REG_CTRL);
  assign push_byte = reg_wr & (lnk.reg_addr == lhc_pkg::REG_FIFO);
  assign req_in = lnk.command_request_pin
    | (ctrl_wr & lnk.reg_wdata[lhc_pkg::CT_REQ]);
  assign clr_in = lnk.interrupt_clear_pin
    | (ctrl_wr & lnk.reg_wdata[lhc_pkg::CT_CLR]);
  assign full = (cnt_ff == (PW+1)'(FIFO_DEPTH));
  assign empty = (cnt_ff == '0);
  // address complete only on the third byte
  assign push_ok = push_byte & (bcnt_ff == 2'(lhc_pkg::ADDR_BYTES - 1))
    & ~full;
  assign start = (state_ff == C_IDLE) & req_pend_ff;
  assign pop = start & ~empty;
  assign done_set = (state_ff == C_WRITE) & lnk.mem_ack;

  // ****************************************
  // address fifo
  // ****************************************
  // byte assembly, low byte first
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bcnt_ff <= '0;
      asm_ff <= '0;
    end else if (push_byte) begin
      asm_ff <= {lnk.reg_wdata, asm_ff[23:8]};
      if (bcnt_ff == 2'(lhc_pkg::ADDR_BYTES - 1)) begin
        bcnt_ff <= '0;
      end else begin
        bcnt_ff <= bcnt_ff + 2'd1;
      end
    end
  end

  // storage, no reset needed
  always_ff @(posedge clk) begin
    if (push_ok) begin
      fifo_mem[wp_ff] <= {lnk.reg_wdata, asm_ff[23:8]};
    end
  end

  // pointers and fill count
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push_ok) wp_ff <= wp_ff + PW'(1);
      if (pop) rp_ff <= rp_ff + PW'(1);
      cnt_ff <= cnt_ff + (PW+1)'(push_ok) - (PW+1)'(pop);
    end
  end

  // pending command request, a new request wins over the take
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      req_pend_ff <= 1'b0;
    end else begin
      req_pend_ff <= req_in | (req_pend_ff & ~start);
    end
  end

  // ****************************************
  // fetch, execute and completion sequence
  // ****************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= C_IDLE;
      idx_ff <= '0;
      base_ff <= '0;
      op_ff <= '0;
      rptr_ff <= '0;
      prm_ff <= '0;
      dflt_ff <= lhc_pkg::DEFAULT_RESET;
      maddr_ff <= '0;
      wdat_ff <= '0;
      mreq_ff <= 1'b0;
      mwe_ff <= 1'b0;
      exe_valid_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        C_IDLE: begin
          if (req_pend_ff) begin
            // empty fifo falls back to the default address
            base_ff <= empty ? dflt_ff : fifo_mem[rp_ff];
            maddr_ff <= empty ? dflt_ff : fifo_mem[rp_ff];
            idx_ff <= '0;
            mreq_ff <= 1'b1;
            mwe_ff <= 1'b0;
            state_ff <= C_FETCH;
          end
        end
        C_FETCH: begin
          if (lnk.mem_ack) begin
            mreq_ff <= 1'b1;
            maddr_ff <= maddr_ff + 24'd1;
            idx_ff <= idx_ff + 3'd1;
            if (idx_ff == 3'(lhc_pkg::TBL_OP)) begin
              op_ff <= lnk.mem_rdata;
            end else if (idx_ff <= 3'(lhc_pkg::TBL_RPTR_LAST)) begin
              rptr_ff <= {lnk.mem_rdata, rptr_ff[23:8]};
            end else begin
              prm_ff <= {lnk.mem_rdata, prm_ff[23:8]};
            end
            if (idx_ff == 3'(lhc_pkg::TBL_RPTR_LAST)
                && op_ff != lhc_pkg::OP_SET_DEFAULT) begin
              mreq_ff <= 1'b0;
              exe_valid_ff <= 1'b1;
              state_ff <= C_EXEC;
            end else if (idx_ff == 3'(lhc_pkg::TBL_PARAM_LAST)) begin
              // new default, then run the command found there
              dflt_ff <= {lnk.mem_rdata, prm_ff[23:8]};
              base_ff <= {lnk.mem_rdata, prm_ff[23:8]};
              maddr_ff <= {lnk.mem_rdata, prm_ff[23:8]};
              idx_ff <= '0;
            end
          end
        end
        C_EXEC: begin
          if (exe_done | exe_refused) begin
            exe_valid_ff <= 1'b0;
            wdat_ff <= exe_refused ? lhc_pkg::CODE_MONITOR
              : lhc_pkg::CODE_OK;
            maddr_ff <= rptr_ff;
            mreq_ff <= 1'b1;
            mwe_ff <= 1'b1;
            state_ff <= C_WRITE;
          end
        end
        C_WRITE: begin
          // interrupt only after the code is stored
          if (lnk.mem_ack) begin
            mreq_ff <= 1'b0;
            mwe_ff <= 1'b0;
            state_ff <= C_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************
  // interrupt causes and status
  // ****************************************
  // one clear drops both causes, a new set wins
  assign nxt_cmd_pend = done_set
    | (cmd_pend_ff & ~clr_in);
  assign nxt_rx_pend = rx_event | (rx_pend_ff & ~clr_in);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmd_pend_ff <= 1'b0;
      rx_pend_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      cmd_pend_ff <= nxt_cmd_pend;
      rx_pend_ff <= nxt_rx_pend;
      irq_ff <= nxt_cmd_pend | nxt_rx_pend;
    end
  end

  // status byte, always presented on the read port
  always_comb begin
    stat = '0;
    stat[lhc_pkg::ST_WR_OK] = ~full;
    stat[lhc_pkg::ST_IRQ] = cmd_pend_ff | rx_pend_ff;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= stat;
    end
  end

  // outputs
  assign lnk.interrupt_pin = irq_ff;
  assign lnk.reg_rdata = rdata_ff;
  assign lnk.mem_req = mreq_ff;
  assign lnk.mem_we = mwe_ff;
  assign lnk.mem_addr = maddr_ff;
  assign lnk.mem_wdata = wdat_ff;
  assign exe_valid = exe_valid_ff;
  assign exe_code = op_ff;
  assign exe_table = base_ff;
endmodule : lhc_ctrl

// ### dv/lhc_sva.sv
// ****************************************
// link checks between host and controller
// ****************************************
module lhc_sva (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // link pins
  input wire logic command_request_pin,
  input wire logic interrupt_clear_pin,
  input wire logic interrupt_pin,
  input wire logic reg_cs,
  input wire logic reg_wr,
  input wire logic reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [23:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_ack,
  // execution side
  input wire logic exe_valid,
  input wire logic exe_done,
  input wire logic exe_refused,
  input wire logic rx_event
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [23:0] asm_ff;
  logic wait_ff;
  wire ctl_wr = reg_cs & reg_wr & (reg_addr == lhc_pkg::REG_CTRL);
  wire fifo_wr = reg_cs & reg_wr & (reg_addr == lhc_pkg::REG_FIFO);
  wire wr_ack = mem_req & mem_we & mem_ack;
  wire wr_ok = reg_rdata[lhc_pkg::ST_WR_OK];
  // collect fifo bytes, low byte first
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) asm_ff <= 24'h000000;
    else if (fifo_wr) asm_ff <= {reg_wdata, asm_ff[23:8]};
  end
  // request seen, first fetch still to come
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) wait_ff <= 1'b0;
    else if (command_request_pin | ctl_wr & reg_wdata[lhc_pkg::CT_REQ])
      wait_ff <= 1'b1;
    else if (mem_req) wait_ff <= 1'b0;
  end
  sequence clr_seen;
    interrupt_clear_pin || ctl_wr && reg_wdata[lhc_pkg::CT_CLR];
  endsequence
  sequence code_wr(logic [7:0] c);
    mem_req && mem_we && mem_wdata == c;
  endsequence
  a_code_ok: assert property (
    exe_valid && exe_done && !exe_refused |-> ##[1:12]
    code_wr(lhc_pkg::CODE_OK)) else $error("accept code not written");
  a_code_refused: assert property (
    exe_valid && exe_refused |-> ##[1:12] code_wr(lhc_pkg::CODE_MONITOR))
    else $error("refuse code not written");
  a_irq_after_write: assert property (
    $rose(interrupt_pin) |-> $past(wr_ack) || $past(wr_ack, 2) ||
    $past(rx_event) || $past(rx_event, 2)) else $error("early interrupt");
  a_irq_flag: assert property (
    $rose(interrupt_pin) |-> ##[0:2] reg_rdata[lhc_pkg::ST_IRQ])
    else $error("pending flag missing");
  // a completion landing in the clear cycle wins, so it is left out
  a_clear_both: assert property (
    clr_seen ##0 !rx_event && !wr_ack ##1 !rx_event |-> ##[0:2]
    !interrupt_pin) else $error("interrupt not cleared");
  a_fetch_start: assert property (
    command_request_pin || ctl_wr && reg_wdata[lhc_pkg::CT_REQ] |->
    ##[1:8] mem_req && !mem_we) else $error("no fetch after request");
  a_fetch_addr: assert property (
    $rose(mem_req) && wait_ff |-> mem_addr == asm_ff)
    else $error("fetch address wrong");
  a_req_hold: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("memory request dropped");
  // host checks the write flag two edges before each fifo byte
  a_fifo_wr_ok: assert property (
    fifo_wr |-> $past(wr_ok, 2)) else $error("fifo written while full");
endmodule : lhc_sva

// ### dv/tb_lan_host_command_interface.sv
// ****************************************
// bench for host and controller ends
// ****************************************
module tb_lan_host_command_interface;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic exe_valid;
  logic [7:0] exe_code;
  logic [23:0] exe_table;
  logic exe_done = 1'b0;
  logic exe_refused = 1'b0;
  logic rx_event = 1'b0;
  logic [31:0] rd;
  logic err;
  int n_errors = 0;
  int n_tests = 0;
  lhc_if lhc_if_inst ();
  lhc_ctrl lhc_ctrl_inst (.lnk(lhc_if_inst.ctrl), .clk(clk), .rstn(rstn),
    .exe_valid(exe_valid), .exe_code(exe_code), .exe_table(exe_table),
    .exe_done(exe_done), .exe_refused(exe_refused), .rx_event(rx_event));
  lhc_host lhc_host_inst (.lnk(lhc_if_inst.host), .clk(clk), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq));
  lhc_sva lhc_sva_inst (.clk(clk), .rstn(rstn),
    .command_request_pin(lhc_if_inst.command_request_pin),
    .interrupt_clear_pin(lhc_if_inst.interrupt_clear_pin),
    .interrupt_pin(lhc_if_inst.interrupt_pin), .reg_cs(lhc_if_inst.reg_cs),
    .reg_wr(lhc_if_inst.reg_wr), .reg_addr(lhc_if_inst.reg_addr),
    .reg_wdata(lhc_if_inst.reg_wdata), .reg_rdata(lhc_if_inst.reg_rdata),
    .mem_req(lhc_if_inst.mem_req), .mem_we(lhc_if_inst.mem_we),
    .mem_addr(lhc_if_inst.mem_addr), .mem_wdata(lhc_if_inst.mem_wdata),
    .mem_ack(lhc_if_inst.mem_ack), .exe_valid(exe_valid),
    .exe_done(exe_done), .exe_refused(exe_refused), .rx_event(rx_event));
  // clock
  always #4 clk = ~clk;
  // verdict
  task automatic end_of_test;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test
  // compare one word
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk32
  // one apb transfer, waits for pready
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (pready !== 1'b1) begin
      n_errors++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // bounded wait: 0 exe_valid, 1 irq, 2 done status bit
  task automatic wait_for(input int s);
    bit hit = 1'b0;
    for (int i = 0; i < 200 && !hit; i++) begin
      if (s == 2) apb(1'b0, lhc_pkg::A_INT_STAT, 32'h0);
      else @(posedge clk);
      hit = (s == 0) ? exe_valid === 1'b1 :
            (s == 1) ? irq === 1'b1 : rd[0] === 1'b1;
    end
    if (!hit) begin
      n_errors++;
      end_of_test();
    end
  endtask : wait_for
  // pulse: 0 done, 1 refused, 2 receive, 3 done with receive
  task automatic pulse(input int s);
    @(posedge clk);
    exe_done <= (s == 0 || s == 3);
    exe_refused <= (s == 1);
    rx_event <= (s >= 2);
    @(posedge clk);
    exe_done <= 1'b0;
    exe_refused <= 1'b0;
    rx_event <= 1'b0;
  endtask : pulse
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, lhc_pkg::A_RESULT, 32'h0);
    chk32(rd, 32'h000000ff);
    apb(1'b0, 8'h20, 32'h0);
    chk32({31'h0, err}, 32'h00000001);
    apb(1'b1, lhc_pkg::A_INT_EN, 32'h00000003);
    apb(1'b1, lhc_pkg::A_CMD, 32'h00000005);
    apb(1'b1, lhc_pkg::A_TABLE, 32'h00000010);
    apb(1'b1, lhc_pkg::A_PARAM, 32'h00123456);
    apb(1'b1, lhc_pkg::A_CTRL, 32'h00000003);
    wait_for(0);
    chk32({24'h0, exe_code}, 32'h00000005);
    chk32({8'h0, exe_table}, 32'h00000010);
    apb(1'b0, lhc_pkg::A_RESULT, 32'h0);
    chk32({31'h0, rd[lhc_pkg::RES_BUSY]}, 32'h00000001);
    pulse(2);
    wait_for(1);
    apb(1'b0, lhc_pkg::A_INT_STAT, 32'h0);
    chk32(rd, 32'h00000002);
    apb(1'b1, lhc_pkg::A_INT_CLR, 32'h00000002);
    pulse(0);
    wait_for(1);
    apb(1'b0, lhc_pkg::A_INT_STAT, 32'h0);
    chk32(rd, 32'h00000001);
    apb(1'b0, lhc_pkg::A_RESULT, 32'h0);
    chk32(rd, 32'h00000000);
    apb(1'b1, lhc_pkg::A_INT_CLR, 32'h00000001);
    apb(1'b1, lhc_pkg::A_INT_EN, 32'h00000000);
    apb(1'b1, lhc_pkg::A_TABLE, 32'h00000020);
    apb(1'b1, lhc_pkg::A_CTRL, 32'h00000001);
    wait_for(0);
    chk32({8'h0, exe_table}, 32'h00000020);
    pulse(1);
    wait_for(2);
    chk32({31'h0, irq}, 32'h00000000);
    apb(1'b0, lhc_pkg::A_RESULT, 32'h0);
    chk32(rd, 32'h0000008a);
    apb(1'b1, lhc_pkg::A_INT_EN, 32'h00000003);
    wait_for(1);
    apb(1'b1, lhc_pkg::A_INT_CLR, 32'h00000001);
    apb(1'b1, lhc_pkg::A_CTRL, 32'h00000003);
    wait_for(0);
    pulse(3);
    wait_for(1);
    apb(1'b0, lhc_pkg::A_INT_STAT, 32'h0);
    chk32(rd, 32'h00000001);
    apb(1'b1, lhc_pkg::A_INT_CLR, 32'h00000003);
    repeat (20) @(posedge clk);
    chk32({31'h0, irq}, 32'h00000000);
    apb(1'b0, lhc_pkg::A_INT_STAT, 32'h0);
    chk32(rd, 32'h00000000);
    end_of_test();
  end
endmodule : tb_lan_host_command_interface
